// ---- design/rxfsp_pkg.sv ----
// Constants and types shared by the receive FIFO control block
package rxfsp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CFG  = 8'h08;
  localparam logic [7:0] A_DPC  = 8'h0c;
  localparam logic [7:0] A_MAC  = 8'h10;
  localparam logic [7:0] A_COE  = 8'h14;
  localparam logic [7:0] A_INFO = 8'h18;
  localparam logic [7:0] A_EVT  = 8'h1c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_OFF  = 0;
  localparam int CFG_DUMP = 8;
  localparam int DPC_SKIP = 0;
  localparam int MAC_RECEIVE_ENABLE = 0;
  localparam int MAC_PBAD = 1;
  localparam int COE_RECEIVE_ENABLE = 0;
  localparam int EVT_ERR  = 0;
  localparam int EVT_HALT = 1;
  localparam int EVT_RUN  = 2;
  localparam int INFO_ST  = 16;
  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int ST_FILT  = 30;
  localparam int ST_LEN   = 16;
  localparam int ST_ES    = 15;
  localparam int ST_BCAST = 13;
  localparam int ST_LERR  = 12;
  localparam int ST_RUNT  = 11;
  localparam int ST_MCAST = 10;
  localparam int ST_LONG  = 7;
  localparam int ST_LCOL  = 6;
  localparam int ST_FTYPE = 5;
  localparam int ST_WDOG  = 4;
  localparam int ST_MII   = 3;
  localparam int ST_DRIB  = 2;
  localparam int ST_CRC   = 1;
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFF_RST   = 5'h00;
  localparam logic        BIT_RST   = 1'b0;
  localparam logic [13:0] RUNT_LEN  = 14'h0040;
  localparam logic [13:0] MAX_LEN   = 14'h05ee;
  localparam logic [13:0] WDOG_LEN  = 14'h0800;
  localparam logic [13:0] HDR_LEN   = 14'h000e;
  localparam logic [13:0] LEN_SAT   = 14'h3fff;
  localparam logic [13:0] TYPE_HI   = 14'h000c;
  localparam logic [13:0] TYPE_LO   = 14'h000d;
  localparam logic [13:0] DA_LEN    = 14'h0006;
  localparam logic [15:0] TYPE_MAX  = 16'h05dc;
  localparam logic [15:0] HDR_FCS   = 16'h0012;
  localparam logic [1:0]  CSUM_LAST = 2'h3;
  localparam logic [2:0]  DRIB_MII  = 3'h4;
  localparam logic [2:0]  DRIB_10M  = 3'h3;
  localparam logic [2:0]  STQ_N     = 3'h4;
  localparam int          MEM_AW    = 6;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [MEM_AW:0]   rxfsp_ptr_t;
  typedef logic [MEM_AW-1:0] rxfsp_addr_t;
  typedef enum logic [2:0] {
    RX_IDLE   = 3'h0,
    RX_FRAME  = 3'h1,
    RX_CSUM   = 3'h3,
    RX_FLUSH  = 3'h2,
    RX_COMMIT = 3'h6
  } rxfsp_state_e;
endpackage

// ---- design/rxfsp_mem_if.sv ----
// Port bundle between the FIFO control and its data memory
interface rxfsp_mem_if;
  logic                     wr_en;
  rxfsp_pkg::rxfsp_addr_t   wr_addr;
  logic [31:0]              wr_data;
  rxfsp_pkg::rxfsp_addr_t   rd_addr;
  logic [31:0]              rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ---- design/rxfsp_mem.sv ----
// Receive data memory with registered read
module rxfsp_mem (
  input wire logic clk,
  rxfsp_mem_if.mem m
);
  logic [31:0] ram [2**rxfsp_pkg::MEM_AW];

  // Read data sample before a same-cycle write lands
  always_ff @(posedge clk) begin
    if (m.wr_en) begin
      ram[m.wr_addr] <= m.wr_data;
    end
    m.rd_data <= ram[m.rd_addr];
  end
endmodule

// ---- design/rxfsp_top.sv ----
// Receive FIFO control: packet skip, flush, data layout, status words, errors
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The implementer's own choices: the strobed register port and the placing of the registers.
module rxfsp_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        mac_rx_valid,
  input  wire logic [7:0]  mac_rx_byte,
  input  wire logic        mac_rx_last,
  input  wire logic [31:0] mac_rx_csum,
  input  wire logic        mac_rx_er,
  input  wire logic        mac_late_coll,
  input  wire logic        mac_filter_fail,
  input  wire logic        mac_crc_bad,
  input  wire logic [2:0]  mac_dribble_bits,
  input  wire logic        mac_speed_10,
  output logic             rx_halted_event,
  output logic             rx_error_flag
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rxfsp_pkg::rxfsp_state_e state, next_state;
  rxfsp_pkg::rxfsp_ptr_t   wr_ptr, commit_ptr, rd_ptr, pkt_start, next_rd_ptr, base_ptr, used;
  rxfsp_pkg::rxfsp_ptr_t   bnd [4];
  logic [31:0] stq [4];
  logic [2:0]  bnd_wp, bnd_rp, st_wp, st_rp;
  logic [4:0]  rx_offset;
  logic        dump, skip, rx_en, pass_bad, csum_en, halt_pend, evt_halt;
  logic [1:0]  lane, base_lane, csum_idx;
  logic [31:0] word_buf, merged, csum_q, st_word, rd_value;
  logic [13:0] len;
  logic [15:0] ltype;
  logic        bcast, mcast, er_seen, coll_seen, ovf_q, fail_q, crc_q, drib_q;
  rxfsp_mem_if mif ();

  rxfsp_mem u_mem (
    .clk (clk),
    .m   (mif.mem)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire cfg_wr  = reg_wr && reg_addr == rxfsp_pkg::A_CFG;
  wire dpc_wr  = reg_wr && reg_addr == rxfsp_pkg::A_DPC;
  wire mac_wr  = reg_wr && reg_addr == rxfsp_pkg::A_MAC;
  wire coe_wr  = reg_wr && reg_addr == rxfsp_pkg::A_COE;
  wire evt_wr  = reg_wr && reg_addr == rxfsp_pkg::A_EVT;
  wire data_rd = reg_rd && reg_addr == rxfsp_pkg::A_DATA;
  wire st_rd   = reg_rd && reg_addr == rxfsp_pkg::A_STAT;

  wire data_empty = rd_ptr == commit_ptr;
  wire st_empty   = st_wp == st_rp;
  wire st_full    = 3'(st_wp - st_rp) == rxfsp_pkg::STQ_N;
  wire bnd_empty  = bnd_wp == bnd_rp;
  wire bnd_full   = 3'(bnd_wp - bnd_rp) == rxfsp_pkg::STQ_N;
  wire [6:0] bnd_head = bnd[bnd_rp[1:0]];

  // A read during a pending skip counts as underrun: the pointer is moving
  wire data_under = data_rd && (data_empty || skip);
  wire data_rd_ok = data_rd && !data_under;
  wire st_under   = st_rd && st_empty;
  wire st_rd_ok   = st_rd && !st_empty;
  wire skip_go    = skip && !bnd_empty;
  wire rd_hits    = data_rd_ok && !bnd_empty && 7'(rd_ptr + 7'h01) == bnd_head;
  wire bnd_pop    = skip_go || rd_hits;

  // ----------------------------------------------------------------
  // Write path and packing
  // ----------------------------------------------------------------
  wire start    = state == rxfsp_pkg::RX_IDLE && mac_rx_valid && rx_en && !dump;
  wire in_frame = state == rxfsp_pkg::RX_FRAME && mac_rx_valid;
  wire in_csum  = state == rxfsp_pkg::RX_CSUM;
  wire byte_ok  = start || in_frame || in_csum;
  wire frm_end  = (start || in_frame) && mac_rx_last;
  wire [7:0] byte_in = in_csum ? csum_q[{csum_idx, 3'h0} +: 8] : mac_rx_byte;
  wire [31:0] byte_word = {24'h0, byte_in} << {base_lane, 3'h0};
  wire word_full = byte_ok && base_lane == 2'h3;
  wire flush_wr  = state == rxfsp_pkg::RX_FLUSH && lane != 2'h0;

  // Leading whole words of the offset are skipped over, not written
  assign base_ptr  = start ? 7'(wr_ptr + {4'h0, rx_offset[4:2]}) : wr_ptr;
  assign base_lane = start ? rx_offset[1:0] : lane;
  assign merged    = (start ? 32'h0 : word_buf) | byte_word;
  assign used      = 7'(base_ptr - rd_ptr);

  // Limitation: an offset jump into a nearly full memory is caught only on the next word
  wire ovf_now   = (word_full || flush_wr) && used[rxfsp_pkg::MEM_AW];
  wire mem_write = (word_full || flush_wr) && !ovf_q && !ovf_now;
  wire is_runt   = len < rxfsp_pkg::RUNT_LEN;
  wire keep      = !ovf_q && !(is_runt && !pass_bad);
  wire commit    = state == rxfsp_pkg::RX_COMMIT;
  wire st_push   = commit && keep && !st_full && !bnd_full;
  wire st_over   = commit && keep && st_full;
  wire halt_go   = halt_pend && state == rxfsp_pkg::RX_IDLE;

  assign mif.wr_en   = mem_write;
  assign mif.wr_addr = base_ptr[rxfsp_pkg::MEM_AW-1:0];
  assign mif.wr_data = flush_wr ? word_buf : merged;
  assign mif.rd_addr = next_rd_ptr[rxfsp_pkg::MEM_AW-1:0];

  // Skip and host data reads never move the status FIFO
  assign next_rd_ptr = dump ? '0 : skip_go ? bnd_head : data_rd_ok ? 7'(rd_ptr + 7'h01) : rd_ptr;

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  wire long_f  = len > rxfsp_pkg::MAX_LEN;
  wire wdog_f  = len > rxfsp_pkg::WDOG_LEN;
  wire has_hdr = len >= rxfsp_pkg::HDR_LEN;
  wire ftype_f = has_hdr && ltype > rxfsp_pkg::TYPE_MAX;
  wire lerr_f  = !is_runt && ltype <= rxfsp_pkg::TYPE_MAX && {2'h0, len} != 16'(ltype + rxfsp_pkg::HDR_FCS);
  wire crc_f   = crc_q || er_seen;

  always_comb begin
    st_word = 32'h0;
    st_word[rxfsp_pkg::ST_FILT] = fail_q;
    st_word[rxfsp_pkg::ST_LEN +: 14] = len;
    st_word[rxfsp_pkg::ST_ES] = is_runt | long_f | coll_seen | crc_f;
    st_word[rxfsp_pkg::ST_BCAST] = bcast;
    st_word[rxfsp_pkg::ST_LERR] = lerr_f;
    st_word[rxfsp_pkg::ST_RUNT] = is_runt;
    st_word[rxfsp_pkg::ST_MCAST] = mcast;
    st_word[rxfsp_pkg::ST_LONG] = long_f;
    st_word[rxfsp_pkg::ST_LCOL] = coll_seen;
    st_word[rxfsp_pkg::ST_FTYPE] = ftype_f;
    st_word[rxfsp_pkg::ST_WDOG] = wdog_f;
    st_word[rxfsp_pkg::ST_MII] = er_seen;
    st_word[rxfsp_pkg::ST_DRIB] = drib_q && !coll_seen;
    st_word[rxfsp_pkg::ST_CRC] = crc_f;
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      rxfsp_pkg::RX_IDLE: begin
        if (frm_end) begin
          next_state = csum_en ? rxfsp_pkg::RX_CSUM : rxfsp_pkg::RX_FLUSH;
        end else if (start) begin
          next_state = rxfsp_pkg::RX_FRAME;
        end
      end
      rxfsp_pkg::RX_FRAME: begin
        if (frm_end) begin
          next_state = csum_en ? rxfsp_pkg::RX_CSUM : rxfsp_pkg::RX_FLUSH;
        end
      end
      rxfsp_pkg::RX_CSUM: begin
        if (csum_idx == rxfsp_pkg::CSUM_LAST) begin
          next_state = rxfsp_pkg::RX_FLUSH;
        end
      end
      rxfsp_pkg::RX_FLUSH: next_state = rxfsp_pkg::RX_COMMIT;
      rxfsp_pkg::RX_COMMIT: next_state = rxfsp_pkg::RX_IDLE;
      default: next_state = rxfsp_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n || dump) begin
      state <= rxfsp_pkg::RX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and packing registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || dump) begin
      wr_ptr     <= '0;
      commit_ptr <= '0;
      rd_ptr     <= '0;
      pkt_start  <= '0;
      lane       <= 2'h0;
      word_buf   <= 32'h0;
      ovf_q      <= 1'b0;
    end else begin
      rd_ptr <= next_rd_ptr;
      if (start) begin
        pkt_start <= wr_ptr;
        ovf_q     <= ovf_now;
      end else if (ovf_now) begin
        ovf_q <= 1'b1;
      end
      if (mem_write) begin
        wr_ptr <= 7'(base_ptr + 7'h01);
      end else if (start) begin
        wr_ptr <= base_ptr;
      end else if (commit && !st_push) begin
        wr_ptr <= pkt_start;
      end
      if (st_push) begin
        commit_ptr <= wr_ptr;
      end
      if (state == rxfsp_pkg::RX_FLUSH) begin
        lane     <= 2'h0;
        word_buf <= 32'h0;
      end else if (byte_ok) begin
        lane     <= 2'(base_lane + 2'h1);
        word_buf <= word_full ? 32'h0 : merged;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame attribute capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      len       <= 14'h0000;
      ltype     <= 16'h0000;
      {bcast, mcast, er_seen, coll_seen, fail_q, crc_q, drib_q} <= 7'h00;
      csum_q    <= 32'h0;
      csum_idx  <= 2'h0;
    end else begin
      if (start) begin
        len       <= 14'h0001;
        bcast     <= &mac_rx_byte;
        mcast     <= mac_rx_byte[0];
        er_seen   <= mac_rx_er;
        coll_seen <= mac_late_coll;
      end else if (in_frame) begin
        len       <= len == rxfsp_pkg::LEN_SAT ? len : 14'(len + 14'h0001);
        er_seen   <= er_seen | mac_rx_er;
        coll_seen <= coll_seen | mac_late_coll;
        if (len < rxfsp_pkg::DA_LEN) begin
          bcast <= bcast & (&mac_rx_byte);
        end
        if (len == rxfsp_pkg::TYPE_HI) begin
          ltype[15:8] <= mac_rx_byte;
        end
        if (len == rxfsp_pkg::TYPE_LO) begin
          ltype[7:0] <= mac_rx_byte;
        end
      end
      if (start) begin
        ltype <= 16'h0000;
      end
      if (frm_end) begin
        csum_q   <= mac_rx_csum;
        csum_idx <= 2'h0;
        fail_q   <= mac_filter_fail;
        crc_q    <= mac_crc_bad;
        drib_q   <= mac_speed_10 ? mac_dribble_bits >= rxfsp_pkg::DRIB_10M
                                 : mac_dribble_bits == rxfsp_pkg::DRIB_MII;
      end else if (in_csum) begin
        csum_idx <= 2'(csum_idx + 2'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and boundary queues
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || dump) begin
      st_wp  <= 3'h0;
      st_rp  <= 3'h0;
      bnd_wp <= 3'h0;
      bnd_rp <= 3'h0;
    end else begin
      if (st_push) begin
        stq[st_wp[1:0]]  <= st_word;
        bnd[bnd_wp[1:0]] <= wr_ptr;
        st_wp  <= 3'(st_wp + 3'h1);
        bnd_wp <= 3'(bnd_wp + 3'h1);
      end
      if (st_rd_ok) begin
        st_rp <= 3'(st_rp + 3'h1);
      end
      if (bnd_pop) begin
        bnd_rp <= 3'(bnd_rp + 3'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and events
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_offset       <= rxfsp_pkg::OFF_RST;
      {dump, skip, rx_en, pass_bad, csum_en} <= {5{rxfsp_pkg::BIT_RST}};
      {halt_pend, evt_halt, rx_halted_event, rx_error_flag} <= 4'h0;
    end else begin
      if (cfg_wr) begin
        rx_offset <= reg_wdata[rxfsp_pkg::CFG_OFF +: 5];
      end
      dump <= cfg_wr && reg_wdata[rxfsp_pkg::CFG_DUMP];
      skip <= dpc_wr && reg_wdata[rxfsp_pkg::DPC_SKIP];
      if (mac_wr) begin
        rx_en    <= reg_wdata[rxfsp_pkg::MAC_RECEIVE_ENABLE];
        pass_bad <= reg_wdata[rxfsp_pkg::MAC_PBAD];
      end
      if (coe_wr) begin
        csum_en <= reg_wdata[rxfsp_pkg::COE_RECEIVE_ENABLE];
      end
      if (mac_wr && rx_en && !reg_wdata[rxfsp_pkg::MAC_RECEIVE_ENABLE]) begin
        halt_pend <= 1'b1;
      end else if (halt_go) begin
        halt_pend <= 1'b0;
      end
      rx_halted_event <= halt_go;
      if (halt_go) begin
        evt_halt <= 1'b1;
      end else if (evt_wr && reg_wdata[rxfsp_pkg::EVT_HALT]) begin
        evt_halt <= 1'b0;
      end
      // New error wins over a clear in the same cycle
      if (data_under || st_under || st_over) begin
        rx_error_flag <= 1'b1;
      end else if (evt_wr && reg_wdata[rxfsp_pkg::EVT_ERR]) begin
        rx_error_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [31:0] info_word = {13'h0, 3'(st_wp - st_rp), 9'h0, 7'(commit_ptr - rd_ptr)};
  wire [31:0] evt_word  = {29'h0, state != rxfsp_pkg::RX_IDLE, evt_halt, rx_error_flag};
  assign rd_value =
    data_rd_ok                   ? mif.rd_data :
    st_rd_ok                     ? stq[st_rp[1:0]] :
    reg_addr == rxfsp_pkg::A_CFG ? {23'h0, dump, 3'h0, rx_offset} :
    reg_addr == rxfsp_pkg::A_DPC ? {31'h0, skip} :
    reg_addr == rxfsp_pkg::A_MAC ? {30'h0, pass_bad, rx_en} :
    reg_addr == rxfsp_pkg::A_COE ? {31'h0, csum_en} :
    reg_addr == rxfsp_pkg::A_INFO ? info_word :
    reg_addr == rxfsp_pkg::A_EVT ? evt_word : 32'h0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_value : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_skip_move;
    skip_go && !dump |=> rd_ptr == $past(bnd_head);
  endproperty
  a_skip_move: assert property (p_skip_move) else $error("skip did not reach next packet");

  property p_skip_clear;
    skip && !dpc_wr |=> !skip;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip bit did not clear");

  property p_skip_status;
    skip_go && !st_rd && !dump |=> st_rp == $past(st_rp);
  endproperty
  a_skip_status: assert property (p_skip_status) else $error("skip moved status FIFO");

  property p_skip_live;
    skip_go && in_frame && !mac_rx_last && !dump |=> state == rxfsp_pkg::RX_FRAME;
  endproperty
  a_skip_live: assert property (p_skip_live) else $error("skip disturbed reception");

  property p_flush;
    dump |=> rd_ptr == '0 && wr_ptr == '0 && commit_ptr == '0 && st_wp == 3'h0 && st_rp == 3'h0;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left pointers");

  sequence s_csum_tail;
    in_csum [*4] ##1 state == rxfsp_pkg::RX_FLUSH;
  endsequence
  property p_csum;
    frm_end && csum_en && !dump |=> s_csum_tail;
  endproperty
  a_csum: assert property (p_csum) else $error("checksum bytes not appended");

  property p_layout;
    st_push |-> st_word[31] == 1'b0 && st_word[14] == 1'b0 && st_word[9:8] == 2'h0 && st_word[0] == 1'b0
                && st_word[29:16] == len;
  endproperty
  a_layout: assert property (p_layout) else $error("status layout wrong");

  property p_summary;
    st_push |-> st_word[15] == (st_word[11] | st_word[7] | st_word[6] | st_word[1]);
  endproperty
  a_summary: assert property (p_summary) else $error("error summary wrong");

  property p_runt_drop;
    commit && is_runt && !pass_bad |=> wr_ptr == $past(pkt_start) && st_wp == $past(st_wp);
  endproperty
  a_runt_drop: assert property (p_runt_drop) else $error("runt kept");

  property p_offset;
    start && !dump |=> lane == 2'($past(rx_offset[1:0]) + 2'h1);
  endproperty
  a_offset: assert property (p_offset) else $error("start offset lost");

  property p_halt;
    halt_go && !dump |=> rx_halted_event ##1 !rx_halted_event;
  endproperty
  a_halt: assert property (p_halt) else $error("halt event not one pulse");

  property p_err;
    data_under || st_under |=> rx_error_flag;
  endproperty
  a_err: assert property (p_err) else $error("underrun not flagged");

  property p_err_hold;
    rx_error_flag && !(evt_wr && reg_wdata[rxfsp_pkg::EVT_ERR]) |=> rx_error_flag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
endmodule

// ---- sim/rxfsp_host.sv ----
// Host bus master model: one-cycle register writes and reads
module rxfsp_host (
  input  wire logic        clk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Data stands one cycle only, so it is taken just after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// ---- sim/tb_rx_fifo_status_path.sv ----
// Self-checking bench for the receive FIFO control block
module tb_rx_fifo_status_path;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, v = 1'b0, last = 1'b0, crc = 1'b0, ff = 1'b0;
  logic er = 1'b0, lc = 1'b0, s10 = 1'b0;
  logic [2:0] db = 3'h0;
  logic [31:0] cs = 32'h00000000;
  logic [7:0] b = 8'h00, addr;
  logic [31:0] wd, rdat, d;
  logic wr, rd, halt, err;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  rxfsp_host i_rxfsp_host (.clk(clk), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat));
  rxfsp_top i_rxfsp_top (.clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .mac_rx_valid(v), .mac_rx_byte(b), .mac_rx_last(last),
    .mac_rx_csum(cs), .mac_rx_er(er), .mac_late_coll(lc), .mac_filter_fail(ff),
    .mac_crc_bad(crc), .mac_dribble_bits(db), .mac_speed_10(s10), .rx_halted_event(halt),
    .rx_error_flag(err));
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("unexpected at %0t got %h exp %h", $time, g, e);
      n_errors++;
    end
  endtask
  // Destination bytes all equal da; type field 0x0800 marks an Ethernet-type frame
  task automatic send(input int n, input logic [7:0] da, input logic bad);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      v    <= 1'b1;
      b    <= k < 6 ? da : k == 12 ? 8'h08 : k == 13 ? 8'h00 : 8'(k);
      last <= k == n - 1;
      crc  <= bad;
      ff   <= bad;
    end
    @(posedge clk);
    v    <= 1'b0;
    last <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_status_skip();
    er <= 1'b1;
    send(64, 8'hff, 1'b1);
    er <= 1'b0;
    i_rxfsp_host.rd(rxfsp_pkg::A_STAT, d);
    chk(d, 32'h4040a42a);
    send(16, 8'h22, 1'b0);
    // Skip lands while a third frame is still arriving
    fork
      send(64, 8'h01, 1'b0);
      begin
        repeat (4) @(posedge clk);
        i_rxfsp_host.wr(rxfsp_pkg::A_DPC, 32'h00000001);
        for (int i = 0; i < 8 && d !== 32'h0; i++) i_rxfsp_host.rd(rxfsp_pkg::A_DPC, d);
        chk(d, 32'h0);
      end
    join
    i_rxfsp_host.rd(rxfsp_pkg::A_INFO, d);
    chk(d, 32'h00020014);
    i_rxfsp_host.rd(rxfsp_pkg::A_DATA, d);
    chk(d, 32'h22222222);
    $display("status and skip test done");
  endtask
  task automatic t_flush();
    i_rxfsp_host.wr(rxfsp_pkg::A_MAC, 32'h00000002);
    for (int i = 0; i < 20 && halt !== 1'b1; i++) @(posedge clk) #1;
    chk({31'h0, halt}, 32'h1);
    i_rxfsp_host.wr(rxfsp_pkg::A_CFG, 32'h00000100);
    i_rxfsp_host.rd(rxfsp_pkg::A_INFO, d);
    chk(d, 32'h0);
    i_rxfsp_host.rd(rxfsp_pkg::A_CFG, d);
    chk(d, 32'h0);
    $display("flush test done");
  endtask
  task automatic t_underrun();
    i_rxfsp_host.rd(rxfsp_pkg::A_STAT, d);
    chk(d, 32'h0);
    repeat (3) @(posedge clk) #1;
    chk({31'h0, err}, 32'h1);
    i_rxfsp_host.wr(rxfsp_pkg::A_EVT, 32'h00000001);
    @(posedge clk) #1;
    chk({31'h0, err}, 32'h0);
    // Pulse reset_n to put every register but the stq and bnd entries and the data memory back to its reset value before the frame test
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    $display("underrun test done");
  endtask
  // Offset 5 and checksum on: word 1 holds bytes 0..2, checksum ends in word 19
  task automatic t_frame();
    i_rxfsp_host.wr(rxfsp_pkg::A_MAC, 32'h00000001);
    i_rxfsp_host.wr(rxfsp_pkg::A_COE, 32'h00000001);
    i_rxfsp_host.wr(rxfsp_pkg::A_CFG, 32'h00000005);
    lc  <= 1'b1;
    db  <= 3'h3;
    s10 <= 1'b1;
    cs  <= 32'hddccbbaa;
    send(20, 8'h01, 1'b0);
    send(70, 8'h01, 1'b0);
    i_rxfsp_host.rd(rxfsp_pkg::A_INFO, d);
    chk(d, 32'h00010014);
    i_rxfsp_host.rd(rxfsp_pkg::A_STAT, d);
    chk(d, 32'h00468460);
    for (int i = 0; i < 20; i++) begin
      i_rxfsp_host.rd(rxfsp_pkg::A_DATA, d);
      if (i == 1) chk(d, 32'h01010100);
      if (i == 18) chk(d, 32'haa454443);
      if (i == 19) chk(d, 32'h00ddccbb);
    end
    chk({31'h0, err}, 32'h0);
    $display("frame layout test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    i_rxfsp_host.wr(rxfsp_pkg::A_MAC, 32'h00000003);
    t_status_skip();
    t_flush();
    t_underrun();
    t_frame();
    results();
  end
endmodule
